/* File: logic/cid_defines.svh */
// cpu injection header decoder: bit positions, register map, reset values
// assumes a 128-bit header word with bit 0 the least significant bit
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH

`define CID_HDR_W       128
`define CID_BYP_BIT     127
`define CID_RVAL_LSB    85
`define CID_RVAL_W      32
`define CID_FWD_LSB     56
`define CID_FWD_W       12
`define CID_FWD_CPU     11
`define CID_PORT_LSB    43
`define CID_PORT_W      4
`define CID_PORT_MAX    4'hc
`define CID_TMR_LSB     37
`define CID_TMR_W       4
`define CID_TMR_MAX     4'h8
`define CID_DP_BIT      30
`define CID_POP_LSB     28
`define CID_POP_W       2
`define CID_POP_NOMOD   2'h3
`define CID_CPU_QUEUE_MASK_LSB    20
`define CID_CPU_QUEUE_MASK_W      8
`define CID_CLASS_LSB   17
`define CID_CLASS_W     3
`define CID_TAGT_BIT    16
`define CID_PCP_LSB     13
`define CID_PCP_W       3
`define CID_DEI_BIT     12
`define CID_VID_LSB     0
`define CID_VID_W       12
`define CID_SLOT_W      10
`define CID_TPID_W      16
`define CID_CTAG_TPID   16'h8100

`define CID_FIFO_DEPTH  8
`define CID_ADDR_W      8

`define CID_REG_CTRL    8'h00
`define CID_REG_STATUS  8'h04
`define CID_REG_COUNT   8'h08
`define CID_CTRL_RST    32'h88a8_0001
`define CID_CTRL_EN     0
`define CID_CTRL_TPID   16
`define CID_ST_EMPTY    0
`define CID_ST_FULL     1
`define CID_ST_BADPORT  2
`define CID_ST_BADTMR   3
`define CID_RESP_OKAY   2'h0
`define CID_RESP_SLVERR 2'h2

`endif

/* File: logic/cid_pkg.sv */
// cpu injection header decoder: shared types
// assumes cid_defines.svh for the field widths
`include "cid_defines.svh"

package cid_pkg;

    typedef struct packed {
        logic                     bypass;
        logic [`CID_FWD_W-1:0]    forward_set_a;
        logic                     to_cpu;
        logic [`CID_CPU_QUEUE_MASK_W-1:0]   cpu_queue_mask;
        logic [`CID_PORT_W-1:0]   ingress_port_number;
        logic [`CID_TMR_W-1:0]    periodic_timer_select;
        logic                     periodic;
        logic [`CID_SLOT_W-1:0]   slot_number;
        logic [`CID_RVAL_W-1:0]   rewriter_value;
        logic                     drop_precedence;
        logic [`CID_POP_W-1:0]    tag_strip_count;
        logic                     rewrite_disable;
        logic [`CID_CLASS_W-1:0]  service_class;
        logic [`CID_TPID_W-1:0]   tpid;
        logic [`CID_PCP_W-1:0]    pcp;
        logic                     dei;
        logic [`CID_VID_W-1:0]    vid;
    } cid_dec_s;

endpackage

/* File: logic/cid_fifo.sv */
// cpu injection header decoder: synchronous fifo with valid/ready both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module cid_fifo #(
    parameter int W = 128,
    parameter int D = 8
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [W-1:0]         in_data,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    output logic [W-1:0]              out_data,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [$clog2(D+1)-1:0]    level
);
    localparam int PW = $clog2(D);
    localparam int CW = $clog2(D+1);

    logic [W-1:0]  mem [D];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic          push;
    logic          pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (level != CW'(D));
    assign out_valid = (level != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap by hand so any depth works, not only powers of two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(D-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(D-1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                level <= level + 1'b1;
            end else if (pop && !push) begin
                level <= level - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

/* File: logic/cid_decoder.sv */
// cpu injection header decoder: header fifo, field decode, axi4-lite regs
// assumes headers arrive from same-clock logic, one 128-bit word each
//
// Notes on behaviour
// - 12-bit forward set at bit 56; top bit is cpu; used only under bypass
// - 4-bit ingress port number at bit 43, legal values 0 to 12
// - 4-bit timer select at bit 37; 1-8 periodic, zero means single injection
// - drop precedence at bit 30, applied only under bypass
// - 2-bit tag strip count at bit 28: strip 0, 1 or 2 tags, bypass only
// - strip count 3 forbids any rewrite except fcs update
// - 8-bit cpu queue mask at bit 20, used under bypass with cpu bit set
// - 3-bit service class at bit 17, used only under bypass
// - bit 16 picks tpid: 0 gives 0x8100, 1 gives service tag value
// - 3-bit pcp at bit 13, used only under bypass
// - dei at bit 12, used only under bypass
// - 12-bit vid at bit 0, used only under bypass
// - nonzero timer select: rewriter value holds slot number 0 to 1023
`include "cid_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cid_decoder #(
    parameter int DEPTH = `CID_FIFO_DEPTH
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // header stream from the injecting cpu
    input  wire logic [`CID_HDR_W-1:0]   hdr_data,
    input  wire logic                    hdr_valid,
    output logic                         hdr_ready,
    // decoded fields towards analyzer and rewriter
    output cid_pkg::cid_dec_s            dec,
    output logic                         dec_valid,
    input  wire logic                    dec_ready,
    // axi4-lite slave
    input  wire logic [`CID_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`CID_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    import cid_pkg::*;

    localparam int LW = $clog2(DEPTH+1);

    logic [`CID_HDR_W-1:0] f_data;
    logic                  f_valid;
    logic                  f_ready;
    logic [LW-1:0]         f_level;
    logic                  in_ready;
    cid_dec_s              next_dec;
    logic                  pop;
    logic [31:0]           ctrl;
    logic                  bad_port;
    logic                  bad_tmr;
    logic [31:0]           count;
    logic [`CID_ADDR_W-1:0] aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  aw_held;
    logic                  w_held;
    logic                  do_write;
    logic                  wr_status;
    logic                  hit_bad_port;
    logic                  hit_bad_tmr;

    ////////////////////////////////////////////////////////////////////////
    // header buffer: a stalled consumer or a cleared enable fills it

    cid_fifo #(
        .W (`CID_HDR_W),
        .D (DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_data   (hdr_data),
        .in_valid  (hdr_valid && hdr_ready),
        .in_ready  (in_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .level     (f_level)
    );

    // ready is registered, so it drops no later than the fifo's own ready and
    // only promises a slot that is certain to stay free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hdr_ready <= 1'b0;
        end else begin
            hdr_ready <= (f_level < LW'(DEPTH - 1)) ||
                         ((f_level == LW'(DEPTH - 1)) && !(hdr_valid && hdr_ready));
        end
    end

    assign pop     = f_valid && ctrl[`CID_CTRL_EN] && (!dec_valid || dec_ready);
    assign f_ready = pop;

    ////////////////////////////////////////////////////////////////////////
    // field decode

    always_comb begin
        next_dec        = '0;
        next_dec.bypass = f_data[`CID_BYP_BIT];
        // reserved ranges are never read
        next_dec.ingress_port_number =
            f_data[`CID_PORT_LSB +: `CID_PORT_W];
        next_dec.periodic_timer_select =
            f_data[`CID_TMR_LSB +: `CID_TMR_W];
        next_dec.periodic = (next_dec.periodic_timer_select != '0);
        next_dec.rewriter_value = f_data[`CID_RVAL_LSB +: `CID_RVAL_W];
        if (next_dec.periodic) begin
            // slot replaces the timestamp; upper bits carry nothing
            next_dec.slot_number = next_dec.rewriter_value[`CID_SLOT_W-1:0];
        end
        // dependence on the injector's header placement
        if (next_dec.bypass) begin
            next_dec.forward_set_a = f_data[`CID_FWD_LSB +: `CID_FWD_W];
            next_dec.to_cpu        = next_dec.forward_set_a[`CID_FWD_CPU];
            if (next_dec.to_cpu) begin
                next_dec.cpu_queue_mask =
                    f_data[`CID_CPU_QUEUE_MASK_LSB +: `CID_CPU_QUEUE_MASK_W];
            end
            next_dec.drop_precedence = f_data[`CID_DP_BIT];
            if (f_data[`CID_POP_LSB +: `CID_POP_W] == `CID_POP_NOMOD) begin
                next_dec.rewrite_disable = 1'b1;
            end else begin
                next_dec.tag_strip_count =
                    f_data[`CID_POP_LSB +: `CID_POP_W];
            end
            next_dec.service_class =
                f_data[`CID_CLASS_LSB +: `CID_CLASS_W];
            next_dec.tpid = f_data[`CID_TAGT_BIT] ?
                ctrl[`CID_CTRL_TPID +: `CID_TPID_W] : `CID_CTAG_TPID;
            next_dec.pcp = f_data[`CID_PCP_LSB +: `CID_PCP_W];
            next_dec.dei = f_data[`CID_DEI_BIT];
            next_dec.vid = f_data[`CID_VID_LSB +: `CID_VID_W];
        end
        // no bypass: all of the above stay zero for the classifier
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dec       <= '0;
            dec_valid <= 1'b0;
        end else if (pop) begin
            dec       <= next_dec;
            dec_valid <= 1'b1;
        end else if (dec_ready) begin
            dec_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status: sticky flags, a set in the clearing cycle wins

    assign hit_bad_port = pop && (next_dec.ingress_port_number > `CID_PORT_MAX);
    assign hit_bad_tmr  = pop && (next_dec.periodic_timer_select > `CID_TMR_MAX);
    assign wr_status    = do_write && (aw_addr == `CID_REG_STATUS) && w_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bad_port <= 1'b0;
        end else if (hit_bad_port) begin
            bad_port <= 1'b1;
        end else if (wr_status && w_data[`CID_ST_BADPORT]) begin
            bad_port <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bad_tmr <= 1'b0;
        end else if (hit_bad_tmr) begin
            bad_tmr <= 1'b1;
        end else if (wr_status && w_data[`CID_ST_BADTMR]) begin
            bad_tmr <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
        end else if (pop) begin
            count <= count + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write side: address and data taken in either order

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CID_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == `CID_REG_CTRL ||
                                 aw_addr == `CID_REG_STATUS ||
                                 aw_addr == `CID_REG_COUNT) ?
                                `CID_RESP_OKAY : `CID_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // control register honours byte strobes lane by lane
    for (genvar b = 0; b < 4; b++) begin : g_ctrl_lane
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ctrl[8*b +: 8] <= 8'(`CID_CTRL_RST >> (8*b));
            end else if (do_write && aw_addr == `CID_REG_CTRL && w_strb[b]) begin
                ctrl[8*b +: 8] <= w_data[8*b +: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read side

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `CID_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `CID_RESP_OKAY;
            case (s_axi_araddr)
                `CID_REG_CTRL: begin
                    s_axi_rdata <= ctrl;
                end
                `CID_REG_STATUS: begin
                    s_axi_rdata <= {28'h0, bad_tmr, bad_port,
                                    (f_level == LW'(DEPTH)), (f_level == '0)};
                end
                `CID_REG_COUNT: begin
                    s_axi_rdata <= count;
                end
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= `CID_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    fwd_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop |=> dec.forward_set_a == ($past(f_data[`CID_BYP_BIT]) ?
                $past(f_data[`CID_FWD_LSB +: `CID_FWD_W]) : '0))
        else $error("forward set does not follow bypass");

    port_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop |=> dec.ingress_port_number ==
                $past(f_data[`CID_PORT_LSB +: `CID_PORT_W]))
        else $error("ingress port not copied");

    timer_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop |=> dec.periodic ==
                ($past(f_data[`CID_TMR_LSB +: `CID_TMR_W]) != '0))
        else $error("periodic flag wrong");

    dp_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop |=> dec.drop_precedence ==
                ($past(f_data[`CID_DP_BIT]) && $past(f_data[`CID_BYP_BIT])))
        else $error("drop precedence gating wrong");

    strip_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dec_valid && dec.rewrite_disable |-> dec.tag_strip_count == '0)
        else $error("strip count with rewrite disabled");

    no_modify_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop && f_data[`CID_BYP_BIT] &&
        f_data[`CID_POP_LSB +: `CID_POP_W] == `CID_POP_NOMOD |=> dec.rewrite_disable)
        else $error("no-modify not raised");

    cpu_queue_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dec_valid && !dec.to_cpu |-> dec.cpu_queue_mask == '0)
        else $error("queue mask without cpu bit");

    class_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop && !f_data[`CID_BYP_BIT] |=> dec.service_class == '0 && !dec.bypass)
        else $error("service class used without bypass");

    tpid_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop && f_data[`CID_BYP_BIT] && !f_data[`CID_TAGT_BIT] |=>
        dec.tpid == `CID_CTAG_TPID)
        else $error("customer tag tpid wrong");

    tag_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop && f_data[`CID_BYP_BIT] |=>
        dec.pcp == $past(f_data[`CID_PCP_LSB +: `CID_PCP_W]) &&
        dec.dei == $past(f_data[`CID_DEI_BIT]))
        else $error("pcp or dei not copied");

    vid_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop |=> dec.vid == ($past(f_data[`CID_BYP_BIT]) ?
                $past(f_data[`CID_VID_LSB +: `CID_VID_W]) : '0))
        else $error("vid gating wrong");

    slot_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pop |=> dec.slot_number ==
                (($past(f_data[`CID_TMR_LSB +: `CID_TMR_W]) != '0) ?
                 $past(f_data[`CID_RVAL_LSB +: `CID_SLOT_W]) : '0))
        else $error("slot number mismatch");

    hold_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dec_valid && !dec_ready |=> dec_valid && $stable(dec))
        else $error("decoded output changed while stalled");

    fifo_room_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hdr_valid && hdr_ready |-> in_ready)
        else $error("header accepted with fifo full");

endmodule

`default_nettype wire

/* File: sim/cid_injector.sv */
// header source model: the injecting cpu side of the decoder
// assumes one clock and the decoder's valid/ready header port
`timescale 1ns/1ps
`default_nettype none

module cid_injector (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    output var logic [127:0]  hdr_data,
    output var logic          hdr_valid,
    input  wire logic         hdr_ready
);
    logic [127:0] q[$];

    task send(input logic [127:0] h);
        q.push_back(h);
    endtask

    // one whole header per transfer, held until taken
    // idle data toggles so a stale word never looks like a fresh header
    always @(posedge aclk) begin
        if (!aresetn) begin
            hdr_valid <= 1'b0;
            hdr_data  <= '0;
        end else begin
            if (hdr_valid && hdr_ready) q.delete(0);
            hdr_valid <= q.size() > 0;
            hdr_data <= q.size() > 0 ? q[0] : ~hdr_data;
        end
    end
endmodule
`default_nettype wire

/* File: sim/cpu_injection_header_decoder_tb.sv */
// testbench for the injection header decoder: scenarios and verdict
// assumes cid_injector as header source and the shared defines
`include "cid_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_injection_header_decoder_tb;
    import cid_pkg::*;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic [127:0]  hdr_data;
    logic          hdr_valid, hdr_ready, dec_valid;
    logic          dec_ready = 1'b1;
    cid_dec_s      dec;
    logic [7:0]    aw_a = '0, ar_a = '0;
    logic [31:0]   w_d = '0, r_d;
    logic          aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0;
    logic          ar_v = 1'b0, r_rd = 1'b0;
    logic          aw_r, w_r, b_v, ar_r, r_v;
    logic [1:0]    b_p, r_p;
    logic [15:0]   tpid_s = 16'h88a8;
    logic [127:0]  exq[$], got[$];
    int            failures = 0;
    int            comparisons = 0;
    int            n_sent = 0;

    initial begin
        forever #20 aclk = ~aclk;
    end

    cid_injector u_cid_injector (.aclk(aclk), .aresetn(aresetn),
        .hdr_data(hdr_data), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready));

    cid_decoder #(.DEPTH(8)) u_cid_decoder (.aclk(aclk), .aresetn(aresetn),
        .hdr_data(hdr_data), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
        .dec(dec), .dec_valid(dec_valid), .dec_ready(dec_ready),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_p), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_p),
        .s_axi_rvalid(r_v), .s_axi_rready(r_rd));

    always @(posedge aclk) begin
        if (aresetn && dec_valid && dec_ready) got.push_back(dec);
    end

    task chk(input string n, input logic [127:0] e, input logic [127:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung write
        do begin
            @(posedge aclk);
            if (aw_v && aw_r) aw_v <= 1'b0;
            if (w_v && w_r) w_v <= 1'b0;
        end while (!b_v);
        b_r <= 1'b0;
        chk("bresp", er, b_p);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_rd <= 1'b1;
        do begin
            @(posedge aclk);
            if (ar_v && ar_r) ar_v <= 1'b0;
        end while (!r_v);
        r_rd <= 1'b0;
        chk("rdata", ed, r_d);
        chk("rresp", er, r_p);
    endtask

    // reserved ranges always zero
    function automatic logic [127:0] hd(input logic b, logic [11:0] f,
        logic [3:0] p, t, logic dp, logic [1:0] pop, logic [7:0] q,
        logic [2:0] c, logic tg, logic [2:0] pc, logic de, logic [11:0] v,
        logic [31:0] rv);
        return {b, 10'h0, rv, 17'h0, f, 9'h0, p, 2'h0, t, 6'h0, dp, pop, q,
                c, tg, pc, de, v};
    endfunction

    function automatic cid_dec_s ex(input logic [127:0] h);
        cid_dec_s e = '0;
        e.bypass = h[127];
        e.ingress_port_number = h[46:43];
        e.periodic_timer_select = h[40:37];
        e.periodic = h[40:37] != 4'h0;
        e.rewriter_value = h[116:85];
        if (e.periodic) e.slot_number = h[94:85];
        if (e.bypass) begin
            e.forward_set_a = h[67:56];
            e.to_cpu = h[67];
            if (h[67]) e.cpu_queue_mask = h[27:20];
            e.drop_precedence = h[30];
            e.rewrite_disable = h[29:28] == 2'h3;
            if (h[29:28] != 2'h3) e.tag_strip_count = h[29:28];
            e.service_class = h[19:17];
            e.tpid = h[16] ? tpid_s : `CID_CTAG_TPID;
            e.pcp = h[15:13];
            e.dei = h[12];
            e.vid = h[11:0];
        end
        return e;
    endfunction

    task send(input logic [127:0] h);
        exq.push_back(ex(h));
        u_cid_injector.send(h);
        n_sent++;
    endtask

    task drain;
        for (int i = 0; i < 300 && got.size() < exq.size(); i++) begin
            @(posedge aclk);
        end
        chk("dec count", exq.size(), got.size());
        while (exq.size() > 0 && got.size() > 0) begin
            chk("dec", exq.pop_front(), got.pop_front());
        end
        exq.delete();
        got.delete();
    endtask

    task t_reset;
        rd(`CID_REG_CTRL, `CID_CTRL_RST, `CID_RESP_OKAY);
        rd(`CID_REG_STATUS, 32'h1, `CID_RESP_OKAY);
        rd(`CID_REG_COUNT, 32'h0, `CID_RESP_OKAY);
        rd(8'h0c, 32'h0, `CID_RESP_SLVERR);
        wr(8'h0c, 32'hffff_ffff, `CID_RESP_SLVERR);
        rd(`CID_REG_CTRL, `CID_CTRL_RST, `CID_RESP_OKAY);
    endtask

    task t_bypass;
        for (int i = 0; i < 4; i++) begin
            send(hd(1'b1, 12'h8a5 ^ 12'(i), 4'(i + 9), 4'h0, i[0], 2'(i),
                8'h5a << i, 3'(i + 5), i[0], 3'(7 - i), ~i[0],
                12'hf00 | 12'(i), 32'h1234_5678));
        end
        send(hd(1'b1, 12'h0a5, 4'h0, 4'h0, 1'b1, 2'h1, 8'hff, 3'h7,
            1'b0, 3'h7, 1'b1, 12'hfff, 32'h0));
        drain;
        wr(`CID_REG_CTRL, 32'h4321_0001, `CID_RESP_OKAY);
        tpid_s = 16'h4321;
        send(hd(1'b1, 12'h800, 4'h1, 4'h0, 1'b0, 2'h2, 8'h81, 3'h3,
            1'b1, 3'h1, 1'b0, 12'h001, 32'h0));
        drain;
    endtask

    task t_nobyp;
        for (int i = 0; i < 3; i++) begin
            send(hd(1'b0, 12'hfff, 4'(i), 4'h0, 1'b1, 2'(i + 1), 8'hff,
                3'h7, 1'b1, 3'h7, 1'b1, 12'hfff, 32'habcd_0000));
        end
        drain;
    endtask

    task t_timer;
        for (int t = 0; t < 9; t++) begin
            send(hd(1'b1, 12'h001, 4'h2, 4'(t), 1'b0, 2'h0, 8'h0, 3'h0,
                1'b0, 3'h0, 1'b0, 12'h0,
                t == 0 ? 32'hdead_beef : 32'(t * 127 + 7)));
        end
        drain;
    endtask

    // far side stalls so the header queue fills and must refuse
    task t_fifo;
        @(posedge aclk);
        dec_ready <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            send(hd(1'b0, 12'h0, 4'h1, 4'h0, 1'b0, 2'h0, 8'h0, 3'h0, 1'b0,
                3'h0, 1'b0, 12'h0, 32'(i)));
        end
        repeat (30) @(posedge aclk);
        chk("hdr_ready", 1'b0, hdr_ready);
        rd(`CID_REG_STATUS, 32'h2, `CID_RESP_OKAY);
        @(posedge aclk);
        dec_ready <= 1'b1;
        drain;
    endtask

    task t_bad;
        send(hd(1'b0, 12'h0, 4'hc, 4'h8, 1'b0, 2'h0, 8'h0, 3'h0, 1'b0,
            3'h0, 1'b0, 12'h0, 32'h3ff));
        drain;
        rd(`CID_REG_STATUS, 32'h1, `CID_RESP_OKAY);
        send(hd(1'b0, 12'h0, 4'hd, 4'h9, 1'b0, 2'h0, 8'h0, 3'h0, 1'b0,
            3'h0, 1'b0, 12'h0, 32'h0));
        drain;
        rd(`CID_REG_STATUS, 32'hd, `CID_RESP_OKAY);
        wr(`CID_REG_STATUS, 32'h4, `CID_RESP_OKAY);
        rd(`CID_REG_STATUS, 32'h9, `CID_RESP_OKAY);
        wr(`CID_REG_STATUS, 32'h8, `CID_RESP_OKAY);
        rd(`CID_REG_STATUS, 32'h1, `CID_RESP_OKAY);
    endtask

    task conclude;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_bypass;
        t_nobyp;
        t_timer;
        t_fifo;
        t_bad;
        rd(`CID_REG_COUNT, n_sent, `CID_RESP_OKAY);
        conclude;
    end

    // the whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        conclude;
    end
endmodule
`default_nettype wire
